// ### hdl/host_port_pkg.sv
// Shared constants, carrier struct and state codes for the host port block
package host_port_pkg;

  // ************************************************************
  // Register port map (word index on reg_addr)
  // ************************************************************
  localparam logic [3:0] ADDR_BSC      = 4'h0; // Bus switching control
  localparam logic [3:0] ADDR_GPIO_DIR = 4'h1; // Byte pin GPIO direction
  localparam logic [3:0] ADDR_GPIO_OUT = 4'h2; // Byte pin GPIO out level
  localparam logic [3:0] ADDR_GPIO_IN  = 4'h3; // Byte pin level, read only
  localparam logic [3:0] ADDR_STATUS   = 4'h4; // Port state, read only
  localparam logic [3:0] ADDR_DATA     = 4'h5; // Host data register
  localparam logic [3:0] ADDR_CTRL     = 4'h6; // Port control register
  localparam logic [3:0] ADDR_HADDR    = 4'h7; // Port address register

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned BSC_SHARED_KEEP_BIT = 0; // Shared keeper enable
  localparam int unsigned BSC_HOST_KEEP_BIT   = 1; // Host keeper enable
  localparam int unsigned STAT_ENABLED_BIT    = 0; // Port enabled by strap
  localparam int unsigned STAT_WIDE_BIT       = 1; // Wide mode select level
  localparam int unsigned STAT_BUSY_BIT       = 2; // Host access in flight
  localparam logic [1:0]  BSC_RESET           = 2'h0;
  localparam logic [7:0]  GPIO_RESET          = 8'h00;
  localparam logic [15:0] REG16_RESET         = 16'h0000;

  // ************************************************************
  // Register select codes from the host
  // ************************************************************
  localparam logic [1:0] SEL_CTRL = 2'h0; // Port control register
  localparam logic [1:0] SEL_DATA = 2'h1; // Data register
  localparam logic [1:0] SEL_ADDR = 2'h2; // Port address register
  localparam logic [1:0] SEL_RSVD = 2'h3; // Reserved, ignored

  // Host control pins grouped as one carrier
  typedef struct packed {
    logic       select_n;  // host_port_select_n
    logic       strobe_n;  // Data strobe, low while transferring
    logic       direction; // host_direction: 1 read, 0 write
    logic [1:0] reg_sel;   // {host_reg_select_hi, host_reg_select_lo}
    logic       byte_pos;  // byte_position_flag: 0 first, 1 second
  } host_ctl_s;

  // Host access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_ACCESS  = 3'b010,
    ST_RECOVER = 3'b100
  } access_e;

endpackage : host_port_pkg

// ### hdl/bus_keeper.sv
// Bus keeper model: tracks last driven level and reports hold activity
`timescale 1ns/1ps
module bus_keeper #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         enable,     // Keeper allowed to hold
  input  wire logic         drive_oe,   // Device drives the pins
  input  wire logic [W-1:0] drive_val,  // Level being driven
  output logic              keep_active,
  output logic [W-1:0]      keep_level
);

  // ************************************************************
  // Hold state
  // ************************************************************
  // Level follows the device's own drive only, so a float keeps it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      keep_level <= {W{1'b0}};
    end else if (drive_oe) begin
      keep_level <= drive_val;
    end
  end

  // Keeper holds only while nobody from this side drives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      keep_active <= 1'b0;
    end else begin
      keep_active <= enable & ~drive_oe;
    end
  end

  a_keep_tracks : assert property (@(posedge clk) disable iff (sys_rst)
    drive_oe |=> keep_level == $past(drive_val))
    else $error("keeper level does not follow last drive");

endmodule : bus_keeper

// ### hdl/host_port_pin_control.sv
// Host port pin control: data pins, keepers, GPIO reuse, host registers
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module host_port_pin_control (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [15:0]                 reg_rdata,
  // Mode and global pins
  input  wire logic                   port_enable_strap,
  input  wire logic                   wide_mode_select,
  input  wire logic                   off_n,
  input  wire logic                   hold_in,
  // Core external memory traffic
  input  wire logic [15:0]            core_data,
  input  wire logic                   core_drive,
  // Host control pins
  input  wire host_port_pkg::host_ctl_s host_ctl,
  // Shared data pins
  input  wire logic [15:0]            shared_data_i,
  output logic [15:0]                 shared_data_o,
  output logic                        shared_data_oe,
  // Host byte data pins
  input  wire logic [7:0]             host_byte_data_i,
  output logic [7:0]                  host_byte_data_o,
  output logic [7:0]                  host_byte_data_oe,
  // Ready pin
  output logic                        host_ready_out,
  output logic                        host_ready_oe,
  // Keeper state
  output logic                        shared_keep_active,
  output logic [15:0]                 shared_keep_level,
  output logic                        host_keep_active,
  output logic [7:0]                  host_keep_level
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [1:0]  bsc_r;            // Keeper enables
  logic [7:0]  gpio_dir_r;       // GPIO drive enables
  logic [7:0]  gpio_out_r;       // GPIO drive levels
  logic [15:0] data_r;           // Host data register
  logic [15:0] ctrl_r;           // Port control register
  logic [15:0] haddr_r;          // Port address register
  logic        port_enabled_r;   // Strap result
  logic        strap_taken_r;    // Strap already sampled
  host_port_pkg::access_e state_r;
  host_port_pkg::access_e state_nxt;
  logic [1:0]  acc_sel_r;        // Latched register select
  logic        acc_read_r;       // Latched direction
  logic        acc_byte_r;       // Latched byte position
  logic        acc_wide_r;       // Access made in wide mode
  logic        acc_start;        // Legal access begins now
  logic        sel_legal;        // Select code usable in this mode
  logic        gpio_mode;        // Byte pins belong to GPIO
  logic        host_wide_read;   // Host reading over shared pins
  logic        host_byte_read;   // Host reading over byte pins
  logic [15:0] sel_word;         // Register the access points at
  logic [7:0]  sel_byte;         // Byte of it for the byte pins

  // ************************************************************
  // Strap capture
  // ************************************************************
  // Caught one edge after release; flop takes constants under reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_enabled_r <= 1'b0;
      strap_taken_r  <= 1'b0;
    end else if (!strap_taken_r) begin
      port_enabled_r <= port_enable_strap;
      strap_taken_r  <= 1'b1;
    end
  end

  // ************************************************************
  // Host access decode
  // ************************************************************
  // Reserved code never starts an access; wide mode only sees data
  always_comb begin
    sel_legal = (host_ctl.reg_sel != host_port_pkg::SEL_RSVD);
    if (wide_mode_select) begin
      sel_legal = (host_ctl.reg_sel == host_port_pkg::SEL_DATA);
    end
  end

  // Select must be low for the access to count at all
  assign acc_start = port_enabled_r && (state_r == host_port_pkg::ST_IDLE)
                     && !host_ctl.select_n && !host_ctl.strobe_n
                     && sel_legal;

  // Route the access to the selected register
  always_comb begin
    case (acc_sel_r)
      host_port_pkg::SEL_CTRL: sel_word = ctrl_r;
      host_port_pkg::SEL_ADDR: sel_word = haddr_r;
      default:                 sel_word = data_r;
    endcase
    sel_byte = acc_byte_r ? sel_word[15:8] : sel_word[7:0];
  end

  // ************************************************************
  // Access sequencer
  // ************************************************************
  // Access lasts while strobe and select stay low; one recovery cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      host_port_pkg::ST_IDLE: begin
        if (acc_start) begin
          state_nxt = host_port_pkg::ST_ACCESS;
        end
      end
      host_port_pkg::ST_ACCESS: begin
        if (host_ctl.strobe_n || host_ctl.select_n) begin
          state_nxt = host_port_pkg::ST_RECOVER;
        end
      end
      host_port_pkg::ST_RECOVER: begin
        state_nxt = host_port_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= host_port_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Access attributes held for the whole access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_sel_r  <= host_port_pkg::SEL_DATA;
      acc_read_r <= 1'b0;
      acc_byte_r <= 1'b0;
      acc_wide_r <= 1'b0;
    end else if (acc_start) begin
      acc_sel_r  <= host_ctl.reg_sel;
      acc_read_r <= host_ctl.direction;
      acc_byte_r <= host_ctl.byte_pos;
      acc_wide_r <= wide_mode_select;
    end
  end

  // Ready low from the access until recovery ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_ready_out <= 1'b0;
      host_ready_oe  <= 1'b0;
    end else begin
      host_ready_out <= port_enabled_r
                        && (state_nxt == host_port_pkg::ST_IDLE);
      host_ready_oe  <= off_n;
    end
  end

  // ************************************************************
  // Host-visible registers
  // ************************************************************
  // Host write wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_r  <= host_port_pkg::REG16_RESET;
      ctrl_r  <= host_port_pkg::REG16_RESET;
      haddr_r <= host_port_pkg::REG16_RESET;
    end else if (acc_start && !host_ctl.direction) begin
      case (host_ctl.reg_sel)
        host_port_pkg::SEL_CTRL: begin
          if (host_ctl.byte_pos) ctrl_r[15:8] <= host_byte_data_i;
          else                   ctrl_r[7:0]  <= host_byte_data_i;
        end
        host_port_pkg::SEL_ADDR: begin
          if (host_ctl.byte_pos) haddr_r[15:8] <= host_byte_data_i;
          else                   haddr_r[7:0]  <= host_byte_data_i;
        end
        default: begin
          if (wide_mode_select) begin
            data_r <= shared_data_i;
          end else if (host_ctl.byte_pos) begin
            data_r[15:8] <= host_byte_data_i;
          end else begin
            data_r[7:0] <= host_byte_data_i;
          end
        end
      endcase
    end else if (reg_wr) begin
      case (reg_addr)
        host_port_pkg::ADDR_DATA:  data_r  <= reg_wdata;
        host_port_pkg::ADDR_CTRL:  ctrl_r  <= reg_wdata;
        host_port_pkg::ADDR_HADDR: haddr_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  // Keeper enables cleared by reset, then under software control
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bsc_r      <= host_port_pkg::BSC_RESET;
      gpio_dir_r <= host_port_pkg::GPIO_RESET;
      gpio_out_r <= host_port_pkg::GPIO_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        host_port_pkg::ADDR_BSC:      bsc_r      <= reg_wdata[1:0];
        host_port_pkg::ADDR_GPIO_DIR: gpio_dir_r <= reg_wdata[7:0];
        host_port_pkg::ADDR_GPIO_OUT: gpio_out_r <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        host_port_pkg::ADDR_BSC:      reg_rdata <= {14'h0000, bsc_r};
        host_port_pkg::ADDR_GPIO_DIR: reg_rdata <= {8'h00, gpio_dir_r};
        host_port_pkg::ADDR_GPIO_OUT: reg_rdata <= {8'h00, gpio_out_r};
        host_port_pkg::ADDR_GPIO_IN:  reg_rdata <= {8'h00, host_byte_data_i};
        host_port_pkg::ADDR_STATUS: begin
          reg_rdata <= {13'h0000,
                        (state_r != host_port_pkg::ST_IDLE),
                        wide_mode_select, port_enabled_r};
        end
        host_port_pkg::ADDR_DATA:     reg_rdata <= data_r;
        host_port_pkg::ADDR_CTRL:     reg_rdata <= ctrl_r;
        host_port_pkg::ADDR_HADDR:    reg_rdata <= haddr_r;
        default:                      reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  assign gpio_mode      = !port_enabled_r || wide_mode_select;
  assign host_wide_read = (state_r == host_port_pkg::ST_ACCESS)
                          && acc_read_r && acc_wide_r;
  assign host_byte_read = (state_r == host_port_pkg::ST_ACCESS)
                          && acc_read_r && !acc_wide_r;

  // Shared pins: any of reset, hold or output-disable wins over drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shared_data_oe <= 1'b0;
      shared_data_o  <= 16'h0000;
    end else begin
      shared_data_oe <= off_n && !hold_in
                        && (core_drive || host_wide_read);
      shared_data_o  <= host_wide_read ? data_r : core_data;
    end
  end

  // Byte pins: GPIO, host read data, or float
  always_ff @(posedge clk) begin
    if (sys_rst || !off_n) begin
      host_byte_data_oe <= 8'h00;
      host_byte_data_o  <= 8'h00;
    end else if (gpio_mode) begin
      host_byte_data_oe <= gpio_dir_r;
      host_byte_data_o  <= gpio_out_r;
    end else if (host_byte_read) begin
      host_byte_data_oe <= 8'hFF;
      host_byte_data_o  <= sel_byte;
    end else begin
      host_byte_data_oe <= 8'h00;
      host_byte_data_o  <= 8'h00;
    end
  end

  // ************************************************************
  // Keepers
  // ************************************************************
  bus_keeper #(.W(16)) u_shared_keeper (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .enable      (bsc_r[host_port_pkg::BSC_SHARED_KEEP_BIT]),
    .drive_oe    (shared_data_oe),
    .drive_val   (shared_data_o),
    .keep_active (shared_keep_active),
    .keep_level  (shared_keep_level)
  );

  // Wide mode forces the host keepers on whatever the bit says
  bus_keeper #(.W(8)) u_host_keeper (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .enable      (wide_mode_select
                  || bsc_r[host_port_pkg::BSC_HOST_KEEP_BIT]),
    .drive_oe    (|host_byte_data_oe),
    .drive_val   (host_byte_data_o),
    .keep_active (host_keep_active),
    .keep_level  (host_keep_level)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_start_kind(logic [1:0] sel, logic wide, logic rd);
    acc_start && host_ctl.reg_sel == sel
    && wide_mode_select == wide && host_ctl.direction == rd;
  endsequence

  a_off_shared_float : assert property (!off_n |=> !shared_data_oe)
    else $error("shared pins driven while output-disable low");
  a_hold_shared_float : assert property (hold_in |=> !shared_data_oe)
    else $error("shared pins driven during hold");
  a_off_byte_float : assert property (
    !off_n |=> host_byte_data_oe == 8'h00)
    else $error("byte pins driven while output-disable low");
  a_ready_float : assert property (!off_n |=> !host_ready_oe)
    else $error("ready driven while output-disable low");
  a_wide_write_lands : assert property (
    s_start_kind(host_port_pkg::SEL_DATA, 1'b1, 1'b0)
    |=> data_r == $past(shared_data_i))
    else $error("wide host write lost");
  a_byte_steer_hi : assert property (
    s_start_kind(host_port_pkg::SEL_DATA, 1'b0, 1'b0) ##0 host_ctl.byte_pos
    |=> data_r[15:8] == $past(host_byte_data_i))
    else $error("second byte not steered to upper half");
  a_rsvd_ignored : assert property (
    state_r == host_port_pkg::ST_IDLE
    && host_ctl.reg_sel == host_port_pkg::SEL_RSVD
    |=> state_r == host_port_pkg::ST_IDLE)
    else $error("reserved select started an access");
  a_wide_no_ctrl : assert property (
    wide_mode_select && host_ctl.reg_sel == host_port_pkg::SEL_CTRL
    && !reg_wr |=> $stable(ctrl_r))
    else $error("control register reached in wide mode");
  a_gpio_drive : assert property (off_n && gpio_mode
    |=> host_byte_data_oe == $past(gpio_dir_r))
    else $error("GPIO direction not applied");
  a_strap_locked : assert property (
    strap_taken_r |=> $stable(port_enabled_r))
    else $error("strap result changed after capture");
  a_wide_keeper_on : assert property (
    wide_mode_select && !(|host_byte_data_oe)
    |=> host_keep_active)
    else $error("host keepers off in wide mode");

endmodule : host_port_pin_control

// ### test/host_model.sv
// Host processor model for the host port control and data pins
`timescale 1ns/1ps
module host_model (
  input  wire logic                     clk,
  input  wire logic                     ready,     // Port ready level
  input  wire logic [7:0]               byte_lvl,  // Byte pin wire level
  input  wire logic [15:0]              wide_lvl,  // Shared pin wire level
  output host_port_pkg::host_ctl_s      ctl,       // Host control pins
  output logic [7:0]                    byte_drv,  // Host side of byte pins
  output logic [15:0]                   wide_drv,  // Host side, shared pins
  output logic                          ok         // Every access recovered
);
  // Idle host: deselected, strobe high
  initial begin
    ctl = 6'h38;
    byte_drv = 8'h00;
    wide_drv = 16'h0000;
    ok = 1'b1;
  end

  // ************************************************************
  // One host access, held for a fixed span
  // ************************************************************
  // No ready handshake inside an access, so the span is fixed
  task automatic access(input logic rd, input logic w, input logic [1:0] sel,
                        input logic bp, input logic [15:0] wd,
                        output logic [15:0] rv);
    int n;
    n = 0;
    @(posedge clk);
    ctl <= {1'b0, 1'b0, rd, sel, bp};
    if (!rd) begin
      byte_drv <= wd[7:0];
      wide_drv <= wd;
    end
    repeat (4) @(posedge clk);
    rv = w ? wide_lvl : {8'h00, byte_lvl};
    ctl <= {1'b1, 1'b1, rd, sel, bp};
    // Released lines flip so a stale value cannot pass
    byte_drv <= ~byte_drv;
    wide_drv <= ~wide_drv;
    while (ready !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    ok = ok & (n < 8);
    @(posedge clk);
  endtask : access
endmodule : host_model

// ### test/host_port_pin_control_tb.sv
// Self-checking bench for the host port pin control block
`timescale 1ns/1ps
module host_port_pin_control_tb;
  logic        clk, sys_rst, reg_wr, reg_rd, strap, wide, off_n, hold_in;
  logic        core_drive, sh_oe, rdy, rdy_oe, sk_act, hk_act, ok;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, core_data, sh_o, sh_i, sk_lvl, wd_drv, v;
  logic [7:0]  hb_o, hb_oe, hb_i, hk_lvl, hb_drv;
  int          error_cnt, n_compared;
  host_port_pkg::host_ctl_s ctl;

  // Wire levels: a driving device wins, else the host side
  assign hb_i = (hb_oe & hb_o) | (~hb_oe & hb_drv);
  assign sh_i = sh_oe ? sh_o : wd_drv;

  host_port_pin_control dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_enable_strap(strap),
    .wide_mode_select(wide), .off_n(off_n), .hold_in(hold_in),
    .core_data(core_data), .core_drive(core_drive), .host_ctl(ctl),
    .shared_data_i(sh_i), .shared_data_o(sh_o), .shared_data_oe(sh_oe),
    .host_byte_data_i(hb_i), .host_byte_data_o(hb_o),
    .host_byte_data_oe(hb_oe), .host_ready_out(rdy),
    .host_ready_oe(rdy_oe), .shared_keep_active(sk_act),
    .shared_keep_level(sk_lvl), .host_keep_active(hk_act),
    .host_keep_level(hk_lvl));

  host_model host (.clk(clk), .ready(rdy), .byte_lvl(hb_i),
    .wide_lvl(sh_i), .ctl(ctl), .byte_drv(hb_drv), .wide_drv(wd_drv),
    .ok(ok));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Register write: one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Register read: data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(nm, e, reg_rdata);
  endtask : rchk

  // Reset held 5 cycles; strap and mode set meanwhile
  task automatic do_reset(input logic s, input logic w);
    @(posedge clk);
    sys_rst <= 1'b1;
    strap <= s;
    wide <= w;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    do_reset(1'b1, 1'b0);
    rchk("status", 4'h4, 16'h0001);
    rchk("bsc", 4'h0, 16'h0000);
    rchk("unmapped", 4'h9, 16'h0000);
    chk("keepers", 16'h0000, {14'h0, sk_act, hk_act});
    chk("shared oe", 16'h0000, {15'h0, sh_oe});
    chk("ready", 16'h0001, {15'h0, rdy});
    $display("test reset done");
  endtask : t_reset

  // Byte steering, all select codes, reads back through the pins
  task automatic t_narrow;
    host.access(1'b0, 1'b0, 2'h1, 1'b0, 16'h005A, v);
    host.access(1'b0, 1'b0, 2'h1, 1'b1, 16'h00C3, v);
    host.access(1'b0, 1'b0, 2'h3, 1'b0, 16'h0077, v);
    rchk("data", 4'h5, 16'hC35A);
    host.access(1'b0, 1'b0, 2'h0, 1'b0, 16'h0011, v);
    rchk("ctrl", 4'h6, 16'h0011);
    host.access(1'b0, 1'b0, 2'h2, 1'b1, 16'h0022, v);
    rchk("haddr", 4'h7, 16'h2200);
    host.access(1'b1, 1'b0, 2'h1, 1'b1, 16'h0000, v);
    chk("read hi", 16'h00C3, v);
    host.access(1'b1, 1'b0, 2'h1, 1'b0, 16'h0000, v);
    chk("read lo", 16'h005A, v);
    chk("host level", 16'h005A, {8'h0, hk_lvl});
    chk("byte oe idle", 16'h0000, {8'h0, hb_oe});
    $display("test narrow done");
  endtask : t_narrow

  // Float conditions and keepers
  task automatic t_pins;
    core_data <= 16'hA5F0;
    core_drive <= 1'b1;
    repeat (2) @(posedge clk);
    chk("shared o", 16'hA5F0, sh_o);
    chk("shared oe on", 16'h0001, {15'h0, sh_oe});
    hold_in <= 1'b1;
    repeat (2) @(posedge clk);
    chk("oe hold", 16'h0000, {15'h0, sh_oe});
    hold_in <= 1'b0;
    off_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("oe off", 16'h0000, {15'h0, sh_oe});
    chk("ready oe off", 16'h0000, {15'h0, rdy_oe});
    chk("byte oe off", 16'h0000, {8'h0, hb_oe});
    off_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ready oe on", 16'h0001, {15'h0, rdy_oe});
    wr(4'h0, 16'h0001);
    core_drive <= 1'b0;
    repeat (3) @(posedge clk);
    chk("shared keep", 16'h0001, {15'h0, sk_act});
    chk("shared level", 16'hA5F0, sk_lvl);
    wr(4'h0, 16'h0002);
    repeat (2) @(posedge clk);
    chk("keep swap", 16'h0001, {14'h0, sk_act, hk_act});
    $display("test pins done");
  endtask : t_pins

  // Wide mode: shared pins carry data, byte pins are GPIO
  task automatic t_wide;
    do_reset(1'b1, 1'b1);
    rchk("status wide", 4'h4, 16'h0003);
    chk("host keep wide", 16'h0001, {15'h0, hk_act});
    wr(4'h1, 16'h00FF);
    wr(4'h2, 16'h003C);
    repeat (2) @(posedge clk);
    chk("gpio oe", 16'h00FF, {8'h0, hb_oe});
    chk("gpio o", 16'h003C, {8'h0, hb_o});
    host.access(1'b0, 1'b1, 2'h1, 1'b0, 16'hBEEF, v);
    rchk("wide data", 4'h5, 16'hBEEF);
    host.access(1'b0, 1'b1, 2'h0, 1'b0, 16'h1234, v);
    rchk("wide ctrl", 4'h6, 16'h0000);
    host.access(1'b1, 1'b1, 2'h1, 1'b0, 16'h0000, v);
    chk("wide read", 16'hBEEF, v);
    $display("test wide done");
  endtask : t_wide

  // Strap low: port stays off even when the strap rises later
  task automatic t_strap_off;
    do_reset(1'b0, 1'b0);
    strap <= 1'b1;
    rchk("status off", 4'h4, 16'h0000);
    chk("host recovered", 16'h0001, {15'h0, ok});
    // A disabled port never raises ready, so the host wait runs out
    host.access(1'b0, 1'b0, 2'h1, 1'b0, 16'h0099, v);
    chk("ready off", 16'h0000, {15'h0, rdy});
    chk("host held off", 16'h0000, {15'h0, ok});
    rchk("data off", 4'h5, 16'h0000);
    wr(4'h1, 16'h000F);
    wr(4'h2, 16'h0005);
    repeat (2) @(posedge clk);
    chk("gpio oe off", 16'h000F, {8'h0, hb_oe});
    chk("gpio o off", 16'h0005, {8'h0, hb_o});
    $display("test strap off done");
  endtask : t_strap_off

  // Hang guard well beyond the whole sequence
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, strap, wide, hold_in, core_drive} = 7'h40;
    off_n = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    core_data = 16'h0000;
    error_cnt = 0;
    n_compared = 0;
    t_reset();
    t_narrow();
    t_pins();
    t_wide();
    t_strap_off();
    final_report();
  end
endmodule : host_port_pin_control_tb
